/* File: rtl/lbs_top.sv */
/*
  lbs_top: start-up, run and drive gating sequencer of a combined dc-output and
  led backlight controller, with an ahb-lite register slave.
  assumes: comparator and host inputs are asynchronous; one core clock;
  synchronous active-low reset standing for the supply power-on reset.
*/
`include "lbs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lbs_top #(
  parameter logic [`LBS_CNT_W-1:0] POR_CYCLES   = `LBS_CNT_W'(`LBS_TPOR_CYC),
  parameter logic [`LBS_CNT_W-1:0] START_COUNT  = `LBS_CNT_W'(`LBS_TSTART_CNT),
  parameter logic [`LBS_CNT_W-1:0] FCT_COUNT    = `LBS_CNT_W'(`LBS_FCT_CNT),
  parameter logic [`LBS_RECYC_W-1:0] RECYC_FULL = {`LBS_RECYC_W{1'b1}}
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // comparators, oscillators and host inputs
  input  wire logic        supply_lockout_ok_i,
  input  wire logic        primary_oscillator_i,
  input  wire logic        sync_i,
  input  wire logic        dc_loop_error_low_i,
  input  wire logic        softstart_integrator_cap_above_i,
  input  wire logic        led_loop_error_off_i,
  input  wire logic        enable_i,
  input  wire logic        enable_conventional_i,
  input  wire logic        dim_i,
  input  wire logic        led_fault_i,
  input  wire logic        system_fault_i,
  // drives and sequencing outputs
  output logic             bridge_drive_first_o,
  output logic             bridge_drive_second_o,
  output logic             led_switch_drive_o,
  output logic             por_o,
  output logic             run_o,
  output logic             cap_discharge_o,
  output logic             softstart_charge_o,
  output logic             integrator_connect_o,
  output logic             integrator_charge_o,
  output logic             fault_clear_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  lbs_sync_if sync_bus ();

  assign sync_bus.raw[`LBS_IN_SUPPLY] = supply_lockout_ok_i;
  assign sync_bus.raw[`LBS_IN_POSC]   = primary_oscillator_i;
  assign sync_bus.raw[`LBS_IN_SYNC]   = sync_i;
  assign sync_bus.raw[`LBS_IN_DCLOW]  = dc_loop_error_low_i;
  assign sync_bus.raw[`LBS_IN_CAP3V]  = softstart_integrator_cap_above_i;
  assign sync_bus.raw[`LBS_IN_LEDOFF] = led_loop_error_off_i;
  assign sync_bus.raw[`LBS_IN_EN]     = enable_i;
  assign sync_bus.raw[`LBS_IN_CONV]   = enable_conventional_i;
  assign sync_bus.raw[`LBS_IN_DIM]    = dim_i;
  assign sync_bus.raw[`LBS_IN_LEDFLT] = led_fault_i;
  assign sync_bus.raw[`LBS_IN_SYSFLT] = system_fault_i;

  lbs_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .port_if    (sync_bus.sync)
  );

  logic supply_ok;
  logic posc;
  logic sync_lvl;
  logic dc_low;
  logic cap_above;
  logic led_off;
  logic en;
  logic conv;
  logic dim;
  logic led_flt;
  logic sys_flt;

  assign supply_ok = sync_bus.clean[`LBS_IN_SUPPLY];
  assign posc      = sync_bus.clean[`LBS_IN_POSC];
  assign sync_lvl  = sync_bus.clean[`LBS_IN_SYNC];
  assign dc_low    = sync_bus.clean[`LBS_IN_DCLOW];
  assign cap_above = sync_bus.clean[`LBS_IN_CAP3V];
  assign led_off   = sync_bus.clean[`LBS_IN_LEDOFF];
  assign en        = sync_bus.clean[`LBS_IN_EN];
  assign conv      = sync_bus.clean[`LBS_IN_CONV];
  assign dim       = sync_bus.clean[`LBS_IN_DIM];
  assign led_flt   = sync_bus.clean[`LBS_IN_LEDFLT];
  assign sys_flt   = sync_bus.clean[`LBS_IN_SYSFLT];

  ////////////////////////////////////////////////////////////////////////////
  // state

  lbs_pkg::lbs_core_type q;
  lbs_pkg::lbs_core_type d;

  logic                    bridge_tick;
  logic                    sync_evt;
  logic                    sec_wrap;
  logic                    en_recycle;
  logic                    sw_restart;
  logic                    restart;
  logic                    active;
  logic                    led_allow;
  logic                    bridge_allow;
  logic                    addr_phase;
  logic [`LBS_ADDR_W-1:0]  a_off;
  logic [31:0]             status_word;

  assign bridge_tick = posc & ~q.osc_prev;
  assign sync_evt    = sync_lvl & ~q.sync_prev;
  assign sec_wrap    = (q.sec == `LBS_SEC_W'(`LBS_SEC_PERIOD - 1));
  assign en_recycle  = en & ~q.en_prev;
  assign active      = (q.st == lbs_pkg::LBS_SOFTSTART) || (q.st == lbs_pkg::LBS_RUN);
  assign addr_phase  = hsel_i & htrans_i[1] & hready_i;
  assign a_off       = haddr_i[`LBS_ADDR_W-1:0];
  assign sw_restart  = q.wr_pend && (q.wr_addr == `LBS_CTRL_OFS) &&
                       hwdata_i[`LBS_CTRL_RESTART];
  assign restart     = active && (en_recycle || sw_restart ||
                       ((q.ledsh || q.allsh) && bridge_tick && (q.recyc == RECYC_FULL)));

  // conventional mode follows dim; integrated mode follows the cap comparator
  assign led_allow   = (q.st == lbs_pkg::LBS_RUN) && en && !q.ledsh && !q.allsh &&
                       (conv ? dim : cap_above);
  assign bridge_allow = active && !dc_low && !q.allsh && !q.hold;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LBS_ST_STATE_LO +: 2] = q.st;
    status_word[`LBS_ST_RUN]    = (q.st == lbs_pkg::LBS_RUN);
    status_word[`LBS_ST_LEDSH]  = q.ledsh;
    status_word[`LBS_ST_ALLSH]  = q.allsh;
    status_word[`LBS_ST_TMO]    = q.tmo;
    status_word[`LBS_ST_FIRST]  = q.first;
    status_word[`LBS_ST_SECOND] = q.second;
    status_word[`LBS_ST_LED]    = q.led;
    status_word[`LBS_ST_MODE]   = conv;
    status_word[`LBS_ST_HOLD]   = q.hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d           = q;
    d.osc_prev  = posc;
    d.sync_prev = sync_lvl;
    d.en_prev   = en;
    d.fclr      = 1'b0;

    // bus slave: capture address phase, act in data phase
    d.wr_pend = addr_phase & hwrite_i;
    d.wr_addr = a_off;
    if (addr_phase && !hwrite_i) begin
      if (a_off == `LBS_CTRL_OFS) begin
        d.rdata = {30'h0, q.hold, 1'b0};
      end else if (a_off == `LBS_STATUS_OFS) begin
        d.rdata = status_word;
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
    if (q.wr_pend && (q.wr_addr == `LBS_CTRL_OFS)) begin
      d.hold = hwdata_i[`LBS_CTRL_HOLD];
    end

    // secondary oscillator, phase locked to each sync event
    if (sync_evt || sec_wrap) begin
      d.sec = '0;
    end else begin
      d.sec = q.sec + `LBS_SEC_W'(1);
    end

    // led drive: rise on discharge edge, fall on loop compare
    if (!led_allow) begin
      d.led = 1'b0;
    end else if (sync_evt || sec_wrap) begin
      d.led = 1'b1;
    end else if (led_off) begin
      d.led = 1'b0;
    end

    // bridge pair: a pair starts with first and ends with second unless allsh is set or the core is no longer active
    if (bridge_tick) begin
      if (q.bphase) begin
        d.first  = 1'b0;
        d.second = !q.allsh && active;
        d.bphase = 1'b0;
      end else if (bridge_allow) begin
        d.first  = 1'b1;
        d.second = 1'b0;
        d.bphase = 1'b1;
      end else begin
        d.first  = 1'b0;
        d.second = 1'b0;
      end
    end

    // fault latches and recycle counter
    if (active && led_flt) begin
      d.ledsh = 1'b1;
    end
    if (active && sys_flt) begin
      d.allsh = 1'b1;
    end
    if ((q.ledsh || q.allsh) && bridge_tick) begin
      d.recyc = q.recyc + `LBS_RECYC_W'(1);
    end

    // periodic fault counter clear
    if (active && bridge_tick) begin
      if (q.fint == FCT_COUNT - `LBS_CNT_W'(1)) begin
        d.fint = '0;
        d.fclr = 1'b1;
      end else begin
        d.fint = q.fint + `LBS_CNT_W'(1);
      end
    end

    case (q.st)
      lbs_pkg::LBS_LOCKOUT: begin
        d.tmr = '0;
        if (supply_ok) begin
          d.st = lbs_pkg::LBS_POR;
        end
      end
      lbs_pkg::LBS_POR: begin
        if (q.tmr >= POR_CYCLES - `LBS_CNT_W'(1)) begin
          d.st  = lbs_pkg::LBS_SOFTSTART;
          d.tmr = '0;
        end else begin
          d.tmr = q.tmr + `LBS_CNT_W'(1);
        end
      end
      lbs_pkg::LBS_SOFTSTART: begin
        if (cap_above) begin
          d.st  = lbs_pkg::LBS_RUN;
          d.tmr = '0;
        end else if (bridge_tick) begin
          if (q.tmr == START_COUNT - `LBS_CNT_W'(1)) begin
            d.st  = lbs_pkg::LBS_POR;
            d.tmr = '0;
            d.tmo = 1'b1;
          end else begin
            d.tmr = q.tmr + `LBS_CNT_W'(1);
          end
        end
      end
      lbs_pkg::LBS_RUN: begin
        d.tmr = '0;
      end
      default: begin
        d.st = lbs_pkg::LBS_LOCKOUT;
      end
    endcase

    // restart clears faults and replays the start-up sequence
    if (restart) begin
      d.st    = lbs_pkg::LBS_POR;
      d.tmr   = '0;
      d.ledsh = 1'b0;
      d.allsh = 1'b0;
      d.recyc = '0;
      d.fint  = '0;
      d.fclr  = 1'b1;
    end

    if (!supply_ok) begin
      d.st = lbs_pkg::LBS_LOCKOUT;
    end

    // power-on reset phase: drives, bridge phase, fault latches, recyc and fint cleared; tmo cleared only in lockout
    if (d.st == lbs_pkg::LBS_LOCKOUT || d.st == lbs_pkg::LBS_POR) begin
      d.first  = 1'b0;
      d.second = 1'b0;
      d.bphase = 1'b0;
      d.led    = 1'b0;
      d.ledsh  = 1'b0;
      d.allsh  = 1'b0;
      d.recyc  = '0;
      d.fint   = '0;
    end
    if (d.st == lbs_pkg::LBS_LOCKOUT) begin
      d.tmo = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.st   <= lbs_pkg::LBS_LOCKOUT;
      q.hold <= `LBS_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout_o           = 1'b1;
  assign hresp_o               = 1'b0;
  assign hrdata_o              = q.rdata;
  assign bridge_drive_first_o  = q.first;
  assign bridge_drive_second_o = q.second;
  assign led_switch_drive_o    = q.led;
  assign por_o                 = (q.st == lbs_pkg::LBS_LOCKOUT) ||
                                 (q.st == lbs_pkg::LBS_POR);
  assign run_o                 = (q.st == lbs_pkg::LBS_RUN);
  assign cap_discharge_o       = por_o;
  assign softstart_charge_o    = (q.st == lbs_pkg::LBS_SOFTSTART);
  assign integrator_connect_o  = run_o;
  assign integrator_charge_o   = run_o && !conv && dim;
  assign fault_clear_o         = q.fclr;

endmodule

`default_nettype wire

/* File: rtl/lbs_map.svh */
/*
  lbs_map.svh: offsets, field positions, reset values and timing counts of the
  backlight start sequencer.
  assumes: included by bare name; definitions only.
*/
`ifndef LBS_MAP_SVH
`define LBS_MAP_SVH

// register byte offsets
`define LBS_CTRL_OFS      12'h000
`define LBS_STATUS_OFS    12'h004
`define LBS_ADDR_W        12

// ctrl fields
`define LBS_CTRL_RESTART  0
`define LBS_CTRL_HOLD     1
`define LBS_CTRL_RST      1'h0

// status fields
`define LBS_ST_STATE_LO   0
`define LBS_ST_RUN        2
`define LBS_ST_LEDSH      3
`define LBS_ST_ALLSH      4
`define LBS_ST_TMO        5
`define LBS_ST_FIRST      6
`define LBS_ST_SECOND     7
`define LBS_ST_LED        8
`define LBS_ST_MODE       9
`define LBS_ST_HOLD       10

// synchronised input bit positions
`define LBS_IN_SUPPLY     0
`define LBS_IN_POSC       1
`define LBS_IN_SYNC       2
`define LBS_IN_DCLOW      3
`define LBS_IN_CAP3V      4
`define LBS_IN_LEDOFF     5
`define LBS_IN_EN         6
`define LBS_IN_CONV       7
`define LBS_IN_DIM        8
`define LBS_IN_LEDFLT     9
`define LBS_IN_SYSFLT     10
`define LBS_IN_N          11

// timing
`define LBS_CLK_NS        10
`define LBS_TPOR_NS       50000
`define LBS_TPOR_CYC      ((`LBS_TPOR_NS + `LBS_CLK_NS - 1) / `LBS_CLK_NS)
`define LBS_TSTART_CNT    32768
`define LBS_FCT_CNT       524288
`define LBS_RECYC_W       19
`define LBS_CNT_W         20
`define LBS_SEC_W         12
`define LBS_SEC_PERIOD    1000

`endif

/* File: rtl/lbs_pkg.sv */
/*
  lbs_pkg: types of the backlight start sequencer.
  assumes: lbs_map.svh is on the include path.
*/
`default_nettype none
`include "lbs_map.svh"

package lbs_pkg;

  typedef enum logic [1:0] {
    LBS_LOCKOUT   = 2'b00,
    LBS_POR       = 2'b01,
    LBS_SOFTSTART = 2'b10,
    LBS_RUN       = 2'b11
  } lbs_seq_type;

  typedef struct packed {
    lbs_seq_type                  st;
    logic [`LBS_CNT_W-1:0]        tmr;
    logic [`LBS_CNT_W-1:0]        fint;
    logic [`LBS_RECYC_W-1:0]      recyc;
    logic [`LBS_SEC_W-1:0]        sec;
    logic                         osc_prev;
    logic                         sync_prev;
    logic                         en_prev;
    logic                         bphase;
    logic                         first;
    logic                         second;
    logic                         led;
    logic                         ledsh;
    logic                         allsh;
    logic                         tmo;
    logic                         fclr;
    logic                         hold;
    logic                         wr_pend;
    logic [`LBS_ADDR_W-1:0]       wr_addr;
    logic [31:0]                  rdata;
  } lbs_core_type;

  typedef struct packed {
    logic [`LBS_IN_N-1:0] s1;
    logic [`LBS_IN_N-1:0] s2;
    logic [`LBS_IN_N-1:0] s3;
    logic [`LBS_IN_N-1:0] clean;
  } lbs_sync_type;

endpackage

`default_nettype wire

/* File: rtl/lbs_sync_if.sv */
/*
  lbs_sync_if: raw pin levels into the synchroniser, clean levels out.
  assumes: one clock domain, the core clock.
*/
`include "lbs_map.svh"
`timescale 1ns/1ps
`default_nettype none

interface lbs_sync_if;
  logic [`LBS_IN_N-1:0] raw;
  logic [`LBS_IN_N-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

`default_nettype wire

/* File: rtl/lbs_sync.sv */
/*
  lbs_sync: three-flop synchroniser bank with agreement filter.
  assumes: raw inputs asynchronous to core_clk_i; synchronous active-low reset.
*/
`include "lbs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lbs_sync (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  lbs_sync_if.sync  port_if
);

  lbs_pkg::lbs_sync_type q;
  lbs_pkg::lbs_sync_type d;

  // first flop feeds only the second; clean follows once second and third agree
  always_comb begin
    d       = q;
    d.s1    = port_if.raw;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.clean = (q.s2 & q.s3) | (q.clean & (q.s2 | q.s3));
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign port_if.clean = q.clean;

endmodule

`default_nettype wire

/* File: sim/lbs_top_sva.sv */
/* lbs_top_sva: port checker of the backlight start sequencer.
   assumes: bound into lbs_top; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module lbs_top_sva #(
  parameter int POR_CYCLES = 5000
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic dim_i,
  input wire logic enable_conventional_i,
  input wire logic dc_loop_error_low_i,
  input wire logic sync_i,
  input wire logic bridge_drive_first_o,
  input wire logic bridge_drive_second_o,
  input wire logic led_switch_drive_o,
  input wire logic por_o,
  input wire logic run_o,
  input wire logic cap_discharge_o,
  input wire logic softstart_charge_o,
  input wire logic integrator_connect_o,
  input wire logic integrator_charge_o,
  input wire logic fault_clear_o
);
  logic [15:0] por_n_q;
  logic [15:0] por_n_d;
  logic [15:0] low_n_q;
  logic [15:0] low_n_d;
  logic [15:0] sy_age_q;
  logic [15:0] sy_age_d;
  logic        sy_prev_q;
  ////////////////////////////////////////
  // run lengths of reset and of a low dc loop error
  always_comb begin
    por_n_d = por_o ? por_n_q + 16'h1 : 16'h0;
    low_n_d = dc_loop_error_low_i ? low_n_q + 16'h1 : 16'h0;
    sy_age_d = (sync_i && !sy_prev_q) ? 16'h0 :
               (sy_age_q == 16'hffff) ? sy_age_q : sy_age_q + 16'h1;
  end
  always_ff @(posedge core_clk_i) begin
    por_n_q <= rst_n_i ? por_n_d : 16'h0;
    low_n_q <= rst_n_i ? low_n_d : 16'h0;
    sy_age_q <= rst_n_i ? sy_age_d : 16'hffff;
    sy_prev_q <= rst_n_i ? sync_i : 1'b0;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_por_drive_off: assert property (por_o && $past(por_o) |-> !led_switch_drive_o
    && !bridge_drive_first_o && !bridge_drive_second_o) else $error("drive on in reset");
  a_discharge_por: assert property (cap_discharge_o == por_o)
    else $error("cap discharge differs from reset");
  a_por_length: assert property ($fell(por_o) |-> por_n_q >= POR_CYCLES
    && softstart_charge_o) else $error("reset too short or no soft start");
  a_run_state: assert property (run_o |-> !por_o && !softstart_charge_o
    && integrator_connect_o) else $error("run flag state wrong");
  a_led_needs_run: assert property (led_switch_drive_o |-> $past(run_o))
    else $error("led drive without run");
  a_dim_gates_led: assert property ((!dim_i && enable_conventional_i)[*8]
    |-> !led_switch_drive_o) else $error("led drive while dimmed off");
  a_dc_low_stop: assert property (low_n_q >= 16'd40 |-> !bridge_drive_first_o
    && !bridge_drive_second_o) else $error("bridge drive with low error");
  a_charge_in_run: assert property (integrator_charge_o == (run_o
    && !$past(enable_conventional_i, 4) && $past(dim_i, 4))) else $error("integrator charge wrong");
  a_led_on_sync: assert property ($rose(led_switch_drive_o) |-> sy_age_q <= 16'd8
    || sy_age_q >= 16'd999) else $error("led drive rise away from sync event");
  a_clear_pulse: assert property (fault_clear_o |=> !fault_clear_o)
    else $error("fault clear longer than one cycle");
  c_run: cover property ($rose(run_o));
  c_led: cover property ($fell(led_switch_drive_o));
  c_clear: cover property (fault_clear_o);
endmodule
bind lbs_top lbs_top_sva #(.POR_CYCLES(POR_CYCLES)) u_sva (.core_clk_i, .rst_n_i, .dim_i,
  .enable_conventional_i, .dc_loop_error_low_i, .sync_i, .bridge_drive_first_o,
  .bridge_drive_second_o,
  .led_switch_drive_o, .por_o, .run_o, .cap_discharge_o, .softstart_charge_o,
  .integrator_connect_o, .integrator_charge_o, .fault_clear_o);
`default_nettype wire

/* File: sim/lbs_analog_model.sv */
/* lbs_analog_model: oscillators, comparators and soft start cap.
   assumes: core clock only; host pins are driven by the bench. */
`timescale 1ns/1ps
`default_nettype none
module lbs_analog_model (
  input  wire logic core_clk_i,
  input  wire logic stuck_i,
  input  wire logic cap_discharge_i,
  input  wire logic softstart_charge_i,
  input  wire logic integrator_charge_i,
  input  wire logic led_i,
  output logic      posc_o,
  output logic      sync_o,
  output logic      cap_above_o,
  output logic      led_off_o
);
  logic [2:0] ph_q = 3'h0;
  logic [5:0] sy_q = 6'h0;
  logic [5:0] lvl_q = 6'h0;
  logic [2:0] on_q = 3'h0;
  ////////////////////////////////////////
  // cap level 40 stands for 3v; led pulses drain it
  always @(posedge core_clk_i) begin
    ph_q <= ph_q + 3'h1;
    sy_q <= (sy_q == 6'h31) ? 6'h0 : sy_q + 6'h1;
    on_q <= !led_i ? 3'h0 : (on_q == 3'h7) ? on_q : on_q + 3'h1;
    if (cap_discharge_i)
      lvl_q <= 6'h0;
    else if ((softstart_charge_i || integrator_charge_i) && !stuck_i && lvl_q != 6'h3f)
      lvl_q <= lvl_q + 6'h1;
    else if (led_i && lvl_q != 6'h0)
      lvl_q <= lvl_q - 6'h1;
  end
  assign posc_o = ph_q[2];
  assign sync_o = sy_q < 6'h4;
  assign cap_above_o = lvl_q >= 6'h28;
  assign led_off_o = on_q >= 3'h5;
endmodule
`default_nettype wire

/* File: sim/lbs_top_test.sv */
/* lbs_top_test: bus and pin driven tests of the start sequencer.
   assumes: lbs_analog_model stands for comparators and oscillators. */
`timescale 1ns/1ps
`default_nettype none
module lbs_top_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwr = 1'b0;
  logic [1:0]  htr = 2'h0;
  logic [31:0] ha = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] rd;
  logic        sup = 1'b0;
  logic        dcl = 1'b0;
  logic        en = 1'b0;
  logic        conv = 1'b1;
  logic        dim = 1'b0;
  logic        lf = 1'b0;
  logic        sf = 1'b0;
  logic        stuck = 1'b0;
  int          errors = 0;
  int          comparisons = 0;
  wire         hrdy, posc, syn, cap, loff, b1, b2, led, por, run, dis, ss, icon, ichg, fclr, hrsp;
  wire  [31:0] hrd;
  wire  [5:0]  obs = {fclr, ichg, b1 | b2, led, run, por};
  lbs_top #(.POR_CYCLES(20'd20), .START_COUNT(20'd16), .FCT_COUNT(20'd32),
    .RECYC_FULL(19'd7)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(ha), .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hrsp), .hrdata_o(hrd),
    .supply_lockout_ok_i(sup), .primary_oscillator_i(posc), .sync_i(syn),
    .dc_loop_error_low_i(dcl), .softstart_integrator_cap_above_i(cap),
    .led_loop_error_off_i(loff), .enable_i(en), .enable_conventional_i(conv), .dim_i(dim),
    .led_fault_i(lf), .system_fault_i(sf), .bridge_drive_first_o(b1),
    .bridge_drive_second_o(b2), .led_switch_drive_o(led), .por_o(por), .run_o(run),
    .cap_discharge_o(dis), .softstart_charge_o(ss), .integrator_connect_o(icon),
    .integrator_charge_o(ichg), .fault_clear_o(fclr));
  lbs_analog_model u_model (.core_clk_i(clk), .stuck_i(stuck), .cap_discharge_i(dis),
    .softstart_charge_i(ss), .integrator_charge_i(ichg), .led_i(led), .posc_o(posc),
    .sync_o(syn), .cap_above_o(cap), .led_off_o(loff));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    ha <= a;
    hwr <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask
  task automatic wt(input int i, input logic v, input int n);
    int k;
    k = 0;
    @(negedge clk);
    while (obs[i] !== v && k < n) begin
      @(negedge clk);
      k++;
    end
    chk(obs[i], v);
    @(posedge clk);
  endtask
  task automatic never(input int i, input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (obs[i] !== 1'b0) s = 1'b1;
    end
    chk(s, 1'b0);
    @(posedge clk);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(por, 1'b1);
    chk(dis, 1'b1);
    ahb(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    chk(hrsp, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h3, 32'h0);
    en <= 1'b1;
    dim <= 1'b1;
    sup <= 1'b1;
    wt(0, 1'b0, 200);
    chk(ss, 1'b1);
    wt(1, 1'b1, 400);
    chk(icon, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h207, 32'h207);
    wt(2, 1'b1, 200);
    wt(2, 1'b0, 40);
    dim <= 1'b0;
    repeat (10) @(posedge clk);
    never(2, 150);
    conv <= 1'b0;
    dim <= 1'b1;
    repeat (8) @(posedge clk);
    chk(ichg, 1'b1);
    wt(2, 1'b1, 300);
    dim <= 1'b0;
    repeat (8) @(posedge clk);
    chk(ichg, 1'b0);
    repeat (400) @(posedge clk);
    never(2, 150);
    conv <= 1'b1;
    dim <= 1'b1;
    dcl <= 1'b1;
    repeat (40) @(posedge clk);
    never(3, 100);
    dcl <= 1'b0;
    wt(3, 1'b1, 100);
    ahb(1'b1, 32'h0, 32'h2);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h2);
    repeat (20) @(posedge clk);
    never(3, 60);
    ahb(1'b1, 32'h0, 32'h0);
    wt(3, 1'b1, 40);
    wt(5, 1'b1, 700);
    never(5, 240);
    wt(5, 1'b1, 40);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    wt(0, 1'b1, 40);
    wt(1, 1'b1, 400);
    ahb(1'b1, 32'h0, 32'h1);
    wt(0, 1'b1, 40);
    wt(1, 1'b1, 400);
    for (int i = 0; i < 2; i++) begin
      lf <= (i == 0);
      sf <= (i == 1);
      repeat (8) @(posedge clk);
      lf <= 1'b0;
      sf <= 1'b0;
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[3+i], 1'b1);
      wt(0, 1'b1, 200);
      wt(1, 1'b1, 400);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[3+i], 1'b0);
    end
    stuck <= 1'b1;
    ahb(1'b1, 32'h0, 32'h1);
    wt(0, 1'b1, 40);
    wt(0, 1'b0, 100);
    wt(0, 1'b1, 300);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[5], 1'b1);
    stuck <= 1'b0;
    wt(1, 1'b1, 400);
    sup <= 1'b0;
    repeat (10) @(posedge clk);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h27, 32'h0);
    results();
  end
endmodule
`default_nettype wire
